// File: bench/pmb_host_model.sv
// Purpose: host configuration software issuing single config cycles
// Assumes: answer arrives within a few clocks of the taking edge
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ns
module pmb_host_model
  import pmb_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              cfg_ack,
  input  wire logic [DATA_W-1:0] cfg_rdata,
  output logic                   cfg_wr,
  output logic                   cfg_rd,
  output logic      [ADDR_W-1:0] cfg_addr,
  output logic      [BE_W-1:0]   cfg_be,
  output logic      [DATA_W-1:0] cfg_wdata
);
  logic ack_seen;

  // idle bus at time zero
  initial
  begin
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // config cycles only; the mapped card region itself is never touched
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] be,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int n;
    cfg_wr    <= wr;
    cfg_rd    <= ~wr;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr    <= 1'b0;
    cfg_rd    <= 1'b0;
    // stale values on released lines could mask a decode that samples late
    cfg_addr  <= ~a;
    cfg_wdata <= ~d;
    n = 0;
    ack_seen = 1'b0;
    while (!ack_seen && n < 8)
    begin
      @(posedge sys_clk);
      ack_seen = (cfg_ack === 1'b1);
      n++;
    end
    q = ack_seen ? cfg_rdata : 'x;
  endtask : access
endmodule : pmb_host_model

// File: bench/tb.sv
// Purpose: self-checking bench for the base address register pair
// Assumes: one tied and one strap-driven instance share the host bus
// Notes:   sel picks which instance answers the host
`timescale 1ns/1ns
module tb;
  import pmb_pkg::*;
  logic        sys_clk, rst, strap, sel;
  logic        cfg_wr, cfg_rd, ack0, ack1;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, rdata0, rdata1, ext0, ext1, card0, card1;
  logic        lock0, lock1;
  int          err_total, checked;

  always #10 sys_clk = ~sys_clk;

  pmb_bar_regs dut_u (.sys_clk(sys_clk), .rst(rst), .card_mode_input(strap), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(rdata0), .cfg_ack(ack0), .ext_region_base(ext0), .card_info_base(card0),
    .card_info_locked(lock0));
  // untied instance lets the card pointer be written when the strap is low
  pmb_bar_regs #(.CARD_MODE_TIED(1'b0)) dut_open_u (.sys_clk(sys_clk), .rst(rst),
    .card_mode_input(strap), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(rdata1), .cfg_ack(ack1),
    .ext_region_base(ext1), .card_info_base(card1), .card_info_locked(lock1));
  pmb_host_model host_u (.sys_clk(sys_clk), .cfg_ack(sel ? ack1 : ack0),
    .cfg_rdata(sel ? rdata1 : rdata0), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    host_u.access(1'b1, a, be, d, q);
    // a write that is never answered counts as a mismatch
    chk({31'h0, host_u.ack_seen}, 32'h0000_0001);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host_u.access(1'b0, a, 4'hF, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rd

  // strap must settle through the sync flops, so reset spans five edges
  task automatic do_reset(input logic s);
    strap <= s;
    rst   <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask : do_reset

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // watchdog: the tests need under a hundred clocks
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    strap = 1'b0;
    sel = 1'b0;
    err_total = 0;
    checked = 0;
    do_reset(1'b0);
    rd(EXT_OFS, 32'h0000_0000);
    rd(CARD_OFS, 32'h0000_0000);
    chk({31'h0, lock0}, 32'h0000_0001);
    $display("test reset_values done");
    wr(EXT_OFS, 4'hF, 32'hFFFF_FFFF);
    rd(EXT_OFS, 32'hFFFF_C000);
    chk(ext0, 32'hFFFF_C000);
    wr(EXT_OFS, 4'hF, 32'h0000_3FFF);
    rd(EXT_OFS, 32'h0000_0000);
    wr(EXT_OFS, 4'hF, 32'h1234_5678);
    rd(EXT_OFS, 32'h1234_4000);
    wr(EXT_OFS, 4'h8, 32'hAB00_0000);
    rd(EXT_OFS, 32'hAB34_4000);
    wr(EXT_OFS, 4'h3, 32'h0000_FFFF);
    rd(EXT_OFS, 32'hAB34_C000);
    wr(EXT_OFS, 4'h0, 32'hFFFF_FFFF);
    rd(EXT_OFS, 32'hAB34_C000);
    $display("test ext_pointer done");
    wr(CARD_OFS, 4'hF, 32'hFFFF_FFFF);
    rd(CARD_OFS, 32'h0000_0000);
    chk(card0, 32'h0000_0000);
    wr(8'h1C, 4'hF, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    rd(EXT_OFS, 32'hAB34_C000);
    $display("test tied_card_and_unmapped done");
    sel <= 1'b1;
    rd(CARD_OFS, 32'hFFFF_F800);
    chk({31'h0, lock1}, 32'h0000_0000);
    wr(CARD_OFS, 4'hF, 32'h8765_47FF);
    rd(CARD_OFS, 32'h8765_4000);
    chk(card1, 32'h8765_4000);
    chk(ext1, 32'hAB34_C000);
    $display("test open_card_pointer done");
    do_reset(1'b1);
    rd(EXT_OFS, 32'h0000_0000);
    rd(CARD_OFS, 32'h0000_0000);
    wr(CARD_OFS, 4'hF, 32'hFFFF_FFFF);
    rd(CARD_OFS, 32'h0000_0000);
    chk({31'h0, lock1}, 32'h0000_0001);
    $display("test strap_lock done");
    print_verdict();
  end
endmodule : tb

// File: common/pmb_bar_if.sv
// Purpose: carries one base register's write strobe and stored value
// Assumes: driven by the decoder on the same clock as the register
// Notes:   value is the registered word, low fields already zero
`timescale 1ns/1ns
interface pmb_bar_if;
  logic        wr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic        lock;
  logic [31:0] value;

  // decoder side drives strobes, register side answers with its word
  modport dec (output wr, output be, output wdata, output lock, input value);
  modport reg_side (input wr, input be, input wdata, input lock, output value);
endinterface : pmb_bar_if

// File: common/pmb_pkg.sv
// Purpose: shared constants for the memory base address register pair
// Assumes: 32-bit configuration data, byte offsets on an 8-bit address
// Notes:   zero fields below each pointer are never stored
package pmb_pkg;
  // access port widths
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          BE_W          = 4;

  // register byte offsets in configuration space
  localparam logic [7:0]  EXT_OFS       = 8'h14;
  localparam logic [7:0]  CARD_OFS      = 8'h18;

  // lowest writable pointer bit of each register
  localparam int          EXT_PTR_LSB   = 14;
  localparam int          CARD_PTR_LSB  = 11;

  // field positions of the read-only low part
  localparam int          SIZE_MSB      = 13;
  localparam int          CARD_SIZE_MSB = 10;
  localparam int          SIZE_LSB      = 4;
  localparam int          PF_BIT        = 3;
  localparam int          TYPE_MSB      = 2;
  localparam int          TYPE_LSB      = 1;
  localparam int          SPACE_BIT     = 0;

  // values seen by software
  localparam logic [31:0] RESET_VAL     = 32'h0000_0000;
  localparam logic [31:0] ALL_ONES      = 32'hFFFF_FFFF;
  localparam logic [31:0] EXT_SIZE_VAL  = 32'hFFFF_C000;
  localparam logic [31:0] EXT_PTR_MASK  = 32'hFFFF_C000;
  localparam logic [31:0] CARD_PTR_MASK = 32'hFFFF_F800;
  localparam logic [3:0]  BE_ALL        = 4'hF;

  // card-mode input is strapped high inside this device
  localparam logic        CARD_TIED     = 1'b1;
endpackage : pmb_pkg

// File: hdl/pmb_bar_regs.sv
// Purpose: extension region and card information base address registers
// Assumes: one configuration read or write per cycle on sys_clk
// Assumes: rst is the global reset, held at least three clock edges
// Notes:   answers every access one cycle later with cfg_ack
// Contract
// - extension register bits 31..14 are read/write base address pointer
// - after writing all ones, extension register reads back FFFF C000
// - extension bits 13..4 read zero; region size is 16K bytes
// - extension bit 3 reads zero: region not prefetchable
// - extension bits 2..1 read zero: 32-bit decoder anywhere in memory
// - extension bit 0 reads zero: region is in memory space
// - card information bits 31..11 hold the upper 21 address bits
// - card-mode high at global reset makes card pointer read-only zeros
// - card-mode input tied high, so card register always reads zero
// - card information bits 10..4 read zero; region size 2K bytes
// - card information bit 3 reads zero: not prefetchable
// - card information bits 2..1 read zero: 32-bit decoder
// - card information bit 0 reads zero: memory space
`timescale 1ns/1ns
module pmb_bar_regs
  import pmb_pkg::*;
#(
  parameter logic CARD_MODE_TIED = CARD_TIED
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              card_mode_input,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire logic [ADDR_W-1:0] cfg_addr,
  input  wire logic [BE_W-1:0]   cfg_be,
  input  wire logic [DATA_W-1:0] cfg_wdata,
  output logic      [DATA_W-1:0] cfg_rdata,
  output logic                   cfg_ack,
  output logic      [DATA_W-1:0] ext_region_base,
  output logic      [DATA_W-1:0] card_info_base,
  output logic                   card_info_locked
);

  // whole state of the decoder
  typedef struct packed {
    logic [1:0]        mode_sync;
    logic              lock;
    logic [DATA_W-1:0] rdata;
    logic              ack;
  } pmb_regs_s;

  pmb_regs_s   st_ff;
  pmb_regs_s   nxt_st;
  logic        ext_hit;
  logic        card_hit;
  logic        any_acc;

  pmb_bar_if   ext_bus ();
  pmb_bar_if   card_bus ();

  // byte lanes are assumed; offsets must be word aligned
  if (EXT_OFS[1:0] != 2'b00 || CARD_OFS[1:0] != 2'b00)
  begin : g_bad_ofs
    $error("pmb_bar_regs: register offsets must be dword aligned");
  end

  // dword decode; the low two address bits are ignored, cfg_be selects lanes
  assign ext_hit  = (cfg_addr[ADDR_W-1:2] == EXT_OFS[ADDR_W-1:2]);
  assign card_hit = (cfg_addr[ADDR_W-1:2] == CARD_OFS[ADDR_W-1:2]);
  assign any_acc  = cfg_wr | cfg_rd;

  // write strobes toward the two registers
  assign ext_bus.wr     = cfg_wr & ext_hit;
  assign ext_bus.be     = cfg_be;
  assign ext_bus.wdata  = cfg_wdata;
  assign ext_bus.lock   = 1'b0;
  assign card_bus.wr    = cfg_wr & card_hit;
  assign card_bus.be    = cfg_be;
  assign card_bus.wdata = cfg_wdata;
  assign card_bus.lock  = st_ff.lock;

  // extension region: pointer from bit 14 up, fixed zeros below
  pmb_bar_word #(
    .PTR_LSB (EXT_PTR_LSB)
  ) u_ext (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (ext_bus)
  );

  // card information region: pointer from bit 11 up
  pmb_bar_word #(
    .PTR_LSB (CARD_PTR_LSB)
  ) u_card (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bus     (card_bus)
  );

  // next state: strap capture, read mux and access answer
  always_comb
  begin
    nxt_st = st_ff;
    // the strap comes from outside the clock, so it is synchronised first
    nxt_st.mode_sync = {st_ff.mode_sync[0], card_mode_input};
    if (rst)
    begin
      // sample while global reset is held; the tie forces lock on anyway
      nxt_st.lock  = st_ff.mode_sync[1] | CARD_MODE_TIED;
      nxt_st.rdata = RESET_VAL;
      nxt_st.ack   = 1'b0;
    end
    else
    begin
      nxt_st.ack = any_acc;
      if (cfg_rd)
      begin
        // read shows the word before any write in the same cycle
        if (ext_hit)
          nxt_st.rdata = ext_bus.value;
        else if (card_hit)
          nxt_st.rdata = card_bus.value;
        else
          nxt_st.rdata = RESET_VAL;                 // other header words
      end
    end
  end

  // one register for all state
  always_ff @(posedge sys_clk)
  begin
    st_ff <= nxt_st;
  end

  // all outputs are flop outputs of this module or of the two words
  assign cfg_rdata        = st_ff.rdata;
  assign cfg_ack          = st_ff.ack;
  assign card_info_locked = st_ff.lock;
  assign ext_region_base  = ext_bus.value;
  assign card_info_base   = card_bus.value;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // full-word write lands in the extension pointer next cycle
  ext_ptr_wr_a: assert property (
    cfg_wr && ext_hit && cfg_be == BE_ALL
    |=> ((ext_region_base ^ $past(cfg_wdata)) & EXT_PTR_MASK) == RESET_VAL)
    else $error("extension pointer did not take written value");

  // sizing write followed by a read reports the region size
  ext_size_rd_a: assert property (
    (cfg_wr && ext_hit && cfg_be == BE_ALL && cfg_wdata == ALL_ONES)
    ##1 (cfg_rd && !cfg_wr && ext_hit)
    |=> cfg_rdata == EXT_SIZE_VAL)
    else $error("extension sizing read returned wrong value");

  // sizing write, one quiet cycle, then a read still reports the region size
  ext_size_gap_a: assert property (
    (cfg_wr && ext_hit && cfg_be == BE_ALL && cfg_wdata == ALL_ONES)
    ##1 !(cfg_wr && ext_hit)
    ##1 (cfg_rd && !cfg_wr && ext_hit)
    |=> cfg_rdata == EXT_SIZE_VAL)
    else $error("extension sizing read after gap returned wrong value");

  // each enabled lane lands in the extension pointer; disabled lanes hold
  for (genvar i = 0; i < BE_W; i++)
  begin : g_ext_lane
    ext_lane_wr_a: assert property (
      cfg_wr && ext_hit && cfg_be[i]
      |=> ext_region_base[8*i +: 8] == ($past(cfg_wdata[8*i +: 8]) & EXT_PTR_MASK[8*i +: 8]))
      else $error("extension lane did not take written byte");
    ext_lane_hold_a: assert property (
      cfg_wr && ext_hit && !cfg_be[i] |=> $stable(ext_region_base[8*i +: 8]))
      else $error("extension lane changed without its enable");
  end

  // unlocked card lanes follow their enables; only pointer bits are kept
  for (genvar i = 0; i < BE_W; i++)
  begin : g_card_lane
    card_lane_wr_a: assert property (
      cfg_wr && card_hit && cfg_be[i] && !card_info_locked
      |=> card_info_base[8*i +: 8] == ($past(cfg_wdata[8*i +: 8]) & CARD_PTR_MASK[8*i +: 8]))
      else $error("card lane did not take written byte");
    card_lane_hold_a: assert property (
      cfg_wr && card_hit && !cfg_be[i] |=> $stable(card_info_base[8*i +: 8]))
      else $error("card lane changed without its enable");
  end

  // a read returns the extension word as it stood when the read was taken
  ext_rd_data_a: assert property (
    cfg_rd && ext_hit |=> cfg_rdata == $past(ext_region_base))
    else $error("extension read data differs from register");

  // a read returns the card word as it stood when the read was taken
  card_rd_data_a: assert property (
    cfg_rd && card_hit |=> cfg_rdata == $past(card_info_base))
    else $error("card read data differs from register");

  // read data is held between reads so a slow host can still take it
  rdata_hold_a: assert property (
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data changed without a read");

  // the lock is only captured during global reset
  lock_hold_a: assert property (
    1'b1 |=> $stable(card_info_locked))
    else $error("card lock changed outside reset");

  // a locked card register never shows a stored pointer
  card_lock_zero_a: assert property (
    card_info_locked |-> card_info_base == RESET_VAL)
    else $error("locked card register shows non-zero value");

  // with the tie in place the lock is always set
  tied_lock_a: assert property (
    CARD_MODE_TIED |-> card_info_locked && card_info_base == RESET_VAL)
    else $error("tied card register not locked at zero");

  // global reset quiets the answer and clears the read data
  ack_rst_a: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    rst |=> !cfg_ack && cfg_rdata == RESET_VAL)
    else $error("answer or read data not cleared by reset");

  // extension size field stays zero
  ext_size_zero_a: assert property (
    ext_region_base[SIZE_MSB:SIZE_LSB] == '0)
    else $error("extension size field not zero");

  // extension prefetch flag stays zero
  ext_pf_zero_a: assert property (
    ext_region_base[PF_BIT] == 1'b0)
    else $error("extension prefetch bit not zero");

  // extension decode type stays zero
  ext_type_zero_a: assert property (
    ext_region_base[TYPE_MSB:TYPE_LSB] == '0)
    else $error("extension decode type not zero");

  // extension space flag stays zero
  ext_space_zero_a: assert property (
    ext_region_base[SPACE_BIT] == 1'b0)
    else $error("extension space flag not zero");

  // unlocked full-word write lands in the card pointer
  card_ptr_wr_a: assert property (
    cfg_wr && card_hit && cfg_be == BE_ALL && !card_info_locked
    |=> ((card_info_base ^ $past(cfg_wdata)) & CARD_PTR_MASK) == RESET_VAL)
    else $error("card pointer did not take written value");

  // a locked card register ignores writes and reads zero
  card_lock_wr_a: assert property (
    card_info_locked && cfg_wr && card_hit
    |=> card_info_base == RESET_VAL && $stable(card_info_locked))
    else $error("locked card register accepted a write");

  // with the tie in place the card register reads zero throughout
  card_tied_a: assert property (
    CARD_MODE_TIED && cfg_rd && card_hit
    |=> card_info_locked && cfg_rdata == RESET_VAL)
    else $error("tied card register read non-zero");

  // card size field stays zero
  card_size_zero_a: assert property (
    card_info_base[CARD_SIZE_MSB:SIZE_LSB] == '0)
    else $error("card size field not zero");

  // card prefetch flag stays zero
  card_pf_zero_a: assert property (
    card_info_base[PF_BIT] == 1'b0)
    else $error("card prefetch bit not zero");

  // card decode type stays zero
  card_type_zero_a: assert property (
    card_info_base[TYPE_MSB:TYPE_LSB] == '0)
    else $error("card decode type not zero");

  // card space flag stays zero
  card_space_zero_a: assert property (
    card_info_base[SPACE_BIT] == 1'b0)
    else $error("card space flag not zero");

  // global reset clears both registers by the next edge
  rst_clear_a: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    rst |=> ext_region_base == RESET_VAL && card_info_base == RESET_VAL)
    else $error("base registers not cleared by reset");

  // writes that enable no lanes leave the extension register alone
  ro_ignore_a: assert property (
    cfg_wr && ext_hit && cfg_be == 4'h0 |=> $stable(ext_region_base))
    else $error("write with no lanes changed extension register");

  // every access is answered exactly one cycle later
  ack_time_a: assert property (
    any_acc |=> cfg_ack ##0 $past(any_acc))
    else $error("access not answered after one cycle");

  // idle cycles give no answer
  ack_idle_a: assert property (
    !any_acc |=> !cfg_ack)
    else $error("answer without access");

  // reads of unmapped words return zero
  unmapped_rd_a: assert property (
    cfg_rd && !ext_hit && !card_hit |=> cfg_rdata == RESET_VAL)
    else $error("unmapped read returned non-zero");

  // main scenarios
  ext_sizing_c: cover property (
    (cfg_wr && ext_hit && cfg_wdata == ALL_ONES) ##2 (cfg_rd && ext_hit));
  ext_program_c: cover property (
    cfg_wr && ext_hit && cfg_be == BE_ALL ##1 ext_region_base != RESET_VAL);
  card_locked_rd_c: cover property (
    card_info_locked && cfg_rd && card_hit);
  card_unlocked_wr_c: cover property (
    !card_info_locked && cfg_wr && card_hit);
  card_open_rd_c: cover property (
    !card_info_locked && cfg_rd && card_hit ##1 cfg_rdata != RESET_VAL);

endmodule : pmb_bar_regs

// File: hdl/pmb_bar_word.sv
// Purpose: one memory base address register with a writable pointer
// Assumes: bits below PTR_LSB are fixed zero (size, prefetch, type, space)
// Notes:   lock clears and freezes the pointer so it reads as zero
`timescale 1ns/1ns
module pmb_bar_word
  import pmb_pkg::*;
#(
  parameter int PTR_LSB = EXT_PTR_LSB
)
(
  input  wire logic  sys_clk,
  input  wire logic  rst,
  pmb_bar_if.reg_side bus
);

  localparam int PW = DATA_W - PTR_LSB;

  typedef struct packed {
    logic [PW-1:0] ptr;
  } pmb_word_s;

  pmb_word_s     st_ff;
  pmb_word_s     nxt_st;
  logic [31:0]   lane_mask;

  // a pointer narrower than one bit or leaving no size bit below it is meaningless
  if (PTR_LSB < SIZE_LSB + 1 || PTR_LSB > DATA_W - 1)
  begin : g_bad_lsb
    $error("pmb_bar_word: PTR_LSB out of range");
  end

  // one byte lane per enable bit
  for (genvar i = 0; i < BE_W; i++)
  begin : g_lane
    assign lane_mask[8*i +: 8] = {8{bus.be[i]}};
  end

  // only enabled lanes of the pointer change; low bits have no storage
  always_comb
  begin
    nxt_st = st_ff;
    if (rst)
      nxt_st.ptr = RESET_VAL[DATA_W-1:PTR_LSB];
    else if (bus.lock)
      nxt_st.ptr = '0;                          // read-only, returns zeros
    else if (bus.wr)
      nxt_st.ptr = (st_ff.ptr & ~lane_mask[DATA_W-1:PTR_LSB])
                 | (bus.wdata[DATA_W-1:PTR_LSB] & lane_mask[DATA_W-1:PTR_LSB]);
  end

  always_ff @(posedge sys_clk)
  begin
    st_ff <= nxt_st;
  end

  assign bus.value = {st_ff.ptr, {PTR_LSB{1'b0}}};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // an unlocked write without enables leaves the word alone
  word_hold_a: assert property (bus.wr && !bus.lock && bus.be == 4'h0
                                |=> $stable(bus.value))
    else $error("base word changed on write with no byte enables");
endmodule : pmb_bar_word
